// *** rtc_alarm_watchdog.sv ***
// What this block does
// - unused time bits and day-alarm bits read zero
// - months bit 7 high stops oscillator
// - months bit 6 low drives 1024 Hz wave
// - hours bit 6 picks 12h, bit 5 PM
// - external time refreshed each hundredth unless frozen
// - internal copy keeps counting while frozen
// - carry and alarm at 99, transfer at rollover
// - alarm mask bits choose match fields
// - all masked: alarm at seconds 59 to 00
// - watchdog period is BCD 00.01 to 99.99
// - watchdog access reloads and clears flag
// - countdown zero fires and restarts repeatedly
// - watchdog reads return stored reload value
// - both watchdog bytes zero disables watchdog
// - command bit 7 low freezes transfers
// - command bit 6 routes alarm and watchdog
// - command bit 5 selects interrupt B drive
// - command bit 4 selects pulse of 3 ms
// - command bit 3 masks watchdog interrupt
// - command bit 2 masks alarm interrupt
// - watchdog flag: set on fire, cleared on access
// - alarm flag: set on match, cleared on access
// - read when we high, ce and oe low
// - write spans ce and we both low
// - command binary, offsets from 0xe not here
`include "rtc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module rtc_alarm_watchdog
    import rtc_pkg::*;
#(
    parameter int unsigned ADDR_W       = 17,
    parameter int unsigned CLK_HZ       = `RTC_CLK_HZ,
    parameter bit          SHARED_PIN_A = 1'b1
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [7:0]        data_in,
    output logic      [7:0]        data_out,
    output logic                   data_out_oe,
    output logic                   irq_out_a_n,
    output logic                   irq_out_a_oe,
    output logic                   irq_out_b,
    output logic                   irq_out_b_oe,
    output logic                   square_wave_out,
    output logic                   square_wave_oe
);

    localparam logic [12:0] TICK_HZ   = 13'(`RTC_TICK_HZ);
    localparam logic [12:0] HUND_HZ   = 13'(`RTC_HUND_HZ);
    localparam logic [3:0]  PULSE_TKS = 4'(`RTC_PULSE_TICKS);

    rtc_byte_t   ext_reg [0:13];
    rtc_byte_t   tm_reg  [0:10];
    rtc_byte_t   tm_next [0:10];
    rtc_byte_t   rd_mux;
    rtc_byte_t   wr_data_reg;
    rtc_byte_t   dmax;
    rtc_byte_t   data_out_reg;
    rtc_bcd16_t  wd_cnt_reg;
    rtc_bcd16_t  wd_load;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [31:0] acc_reg;
    logic [12:0] hacc_reg;
    logic [1:0]  sqw_cnt_reg;
    logic [1:0]  flag_reg;
    logic [1:0]  set_ev;
    logic [1:0]  clr_ev;
    logic [1:0]  src_act;
    logic        tick_reg;
    logic        hund_tick_reg;
    logic        rd_active;
    logic        rd_active_reg;
    logic        wr_active;
    logic        wr_active_reg;
    logic        rd_start;
    logic        wr_commit;
    logic        wr_hit;
    logic        acc_hit;
    logic [3:0]  wr_off;
    logic [3:0]  acc_off;
    logic        c_min;
    logic        c_hr;
    logic        c_day;
    logic        c_mon;
    logic        c_yr;
    logic        alm_match;
    logic        tod_event;
    logic        wd_en;
    logic        wd_event;
    logic        wd_access;
    logic        alm_access;
    logic        osc_run;
    logic        te;
    logic        a_act;
    logic        b_act;
    logic        irq_a_n_reg;
    logic        irq_a_oe_reg;
    logic        irq_b_reg;
    logic        irq_b_oe_reg;
    logic        sqw_reg;

    // bcd helpers
    function automatic rtc_byte_t bcd_inc(input rtc_byte_t v);
        if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic rtc_bcd16_t bcd_dec(input rtc_bcd16_t v);
        rtc_bcd16_t r;
        logic       borrow;
        r = v;
        borrow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (borrow) begin
                if (r[i*4 +: 4] == 4'h0) begin
                    r[i*4 +: 4] = 4'h9;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // writable bits per offset, unused bits held at zero
    function automatic rtc_byte_t wr_mask(input logic [3:0] off);
        unique case (off)
            `RTC_SECONDS_COUNT, `RTC_MINUTES_COUNT,
            `RTC_HOURS_COUNT:           return 8'h7f;
            `RTC_WEEKDAY_COUNT:         return 8'h07;
            `RTC_DAY_ALARM:             return 8'h87;
            `RTC_DATE_COUNT:            return 8'h3f;
            `RTC_MONTH_AND_OSC_CONTROL: return 8'hdf;
            `RTC_COMMAND_CONTROL_FLAGS: return 8'hfc;
            default:                    return 8'hff;
        endcase
    endfunction

    function automatic logic is_time(input int i);
        return i != 3 && i != 5 && i != 7;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // host strobes
    assign rd_active = !ce_n && !oe_n && we_n;
    assign wr_active = !ce_n && !we_n;
    assign rd_start  = rd_active && !rd_active_reg;
    assign wr_commit = wr_active_reg && !wr_active;
    assign wr_off    = wr_addr_reg[3:0];
    assign wr_hit    = wr_addr_reg <= ADDR_W'(`RTC_LAST_OFFSET);
    assign acc_off   = wr_commit ? wr_off : addr[3:0];
    assign acc_hit   = wr_commit ? wr_hit
                                 : addr <= ADDR_W'(`RTC_LAST_OFFSET);
    assign wd_access = (rd_start || wr_commit) && acc_hit
                       && acc_off[3:1] == 3'h6;
    assign alm_access = (rd_start || wr_commit) && acc_hit
                        && (acc_off == `RTC_MINUTE_ALARM
                            || acc_off == `RTC_HOUR_ALARM
                            || acc_off == `RTC_DAY_ALARM);
    assign te      = ext_reg[11][`RTC_CMD_TRANSFER_BIT];
    assign osc_run = !ext_reg[9][`RTC_MON_OSC_STOP_N_BIT];

    // strobe history and write capture at the trailing edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_active_reg <= 1'b0;
            wr_active_reg <= 1'b0;
            wr_addr_reg   <= '0;
            wr_data_reg   <= 8'h00;
        end else begin
            rd_active_reg <= rd_active;
            wr_active_reg <= wr_active;
            if (wr_active) begin
                wr_addr_reg <= addr;
                wr_data_reg <= data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // 4096 Hz prescaler, hundredths and square wave
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_reg  <= 32'h0;
            tick_reg <= 1'b0;
        end else if (!osc_run) begin
            tick_reg <= 1'b0;
        end else if (acc_reg + 32'(`RTC_TICK_HZ) >= CLK_HZ) begin
            acc_reg  <= acc_reg + 32'(`RTC_TICK_HZ) - CLK_HZ;
            tick_reg <= 1'b1;
        end else begin
            acc_reg  <= acc_reg + 32'(`RTC_TICK_HZ);
            tick_reg <= 1'b0;
        end
    end

    // divide by 40.96 and by 4
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hacc_reg      <= 13'h0;
            hund_tick_reg <= 1'b0;
            sqw_cnt_reg   <= 2'h0;
        end else begin
            hund_tick_reg <= 1'b0;
            if (tick_reg) begin
                sqw_cnt_reg <= sqw_cnt_reg + 2'h1;
                if (hacc_reg + HUND_HZ >= TICK_HZ) begin
                    hacc_reg      <= hacc_reg + HUND_HZ - TICK_HZ;
                    hund_tick_reg <= 1'b1;
                end else begin
                    hacc_reg <= hacc_reg + HUND_HZ;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // calendar carry chain
    always_comb begin
        tm_next = tm_reg;
        dmax = (tm_reg[9] == 8'h02)
               ? ((tm_reg[10][4] ? (tm_reg[10][3:0] == 4'h2
                                    || tm_reg[10][3:0] == 4'h6)
                                 : (tm_reg[10][1:0] == 2'h0
                                    && tm_reg[10][3:0] != 4'hc))
                  ? 8'h29 : 8'h28)
               : (tm_reg[9] == 8'h04 || tm_reg[9] == 8'h06
                  || tm_reg[9] == 8'h09 || tm_reg[9] == 8'h11)
                 ? 8'h30 : 8'h31;
        tm_next[0] = (tm_reg[0] == 8'h99) ? 8'h00 : bcd_inc(tm_reg[0]);
        c_min = tm_reg[0] == 8'h99 && tm_reg[1] == 8'h59;
        if (tm_reg[0] == 8'h99)
            tm_next[1] = (tm_reg[1] == 8'h59) ? 8'h00 : bcd_inc(tm_reg[1]);
        c_hr = c_min && tm_reg[2] == 8'h59;
        if (c_min)
            tm_next[2] = (tm_reg[2] == 8'h59) ? 8'h00 : bcd_inc(tm_reg[2]);
        // 12 hour wraps 11 to 12 with am/pm flip, 24 hour at 23
        if (tm_reg[4][`RTC_HR_12H_BIT])
            c_day = c_hr && tm_reg[4][`RTC_HR_PM_BIT]
                    && tm_reg[4][4:0] == 5'h11;
        else
            c_day = c_hr && tm_reg[4][5:0] == 6'h23;
        if (c_hr) begin
            if (tm_reg[4][`RTC_HR_12H_BIT]) begin
                if (tm_reg[4][4:0] == 5'h12)
                    tm_next[4] = {tm_reg[4][7:5], 5'h01};
                else if (tm_reg[4][4:0] == 5'h11)
                    tm_next[4] = {tm_reg[4][7:6], !tm_reg[4][5], 5'h12};
                else
                    tm_next[4] = bcd_inc(tm_reg[4]);
            end else if (tm_reg[4][5:0] == 6'h23) begin
                tm_next[4] = {tm_reg[4][7:6], 6'h00};
            end else begin
                tm_next[4] = bcd_inc(tm_reg[4]);
            end
        end
        c_mon = c_day && tm_reg[8] == dmax;
        c_yr  = c_mon && tm_reg[9] == 8'h12;
        if (c_day) begin
            tm_next[6] = (tm_reg[6] == 8'h07) ? 8'h01 : bcd_inc(tm_reg[6]);
            tm_next[8] = (tm_reg[8] == dmax) ? 8'h01 : bcd_inc(tm_reg[8]);
        end
        if (c_mon)
            tm_next[9] = (tm_reg[9] == 8'h12) ? 8'h01 : bcd_inc(tm_reg[9]);
        if (c_yr)
            tm_next[10] = (tm_reg[10] == 8'h99) ? 8'h00
                                                : bcd_inc(tm_reg[10]);
    end

    // internal copy counts regardless of transfer freeze
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i <= 10; i++)
                tm_reg[i] <= (i == 6 || i == 8 || i == 9) ? `RTC_ONE_RST
                                                          : 8'h00;
        end else begin
            if (hund_tick_reg)
                tm_reg <= tm_next;
            if (wr_commit && wr_hit && wr_off <= `RTC_YEAR_COUNT
                && is_time(int'(wr_off)))
                tm_reg[wr_off] <= (wr_off == `RTC_MONTH_AND_OSC_CONTROL)
                                  ? {3'h0, wr_data_reg[4:0]}
                                  : wr_data_reg & wr_mask(wr_off);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // time-of-day alarm: checked on the minute rollover
    always_comb begin
        unique case ({ext_reg[3][7], ext_reg[5][7], ext_reg[7][7]})
            3'b111: alm_match = 1'b1;
            3'b011: alm_match = tm_next[2][6:0] == ext_reg[3][6:0];
            3'b001: alm_match = tm_next[2][6:0] == ext_reg[3][6:0]
                                && tm_next[4][6:0] == ext_reg[5][6:0];
            3'b000: alm_match = tm_next[2][6:0] == ext_reg[3][6:0]
                                && tm_next[4][6:0] == ext_reg[5][6:0]
                                && tm_next[6][2:0] == ext_reg[7][2:0];
            default: alm_match = 1'b0;
        endcase
    end
    assign tod_event = hund_tick_reg && c_min && alm_match;

    ////////////////////////////////////////////////////////////////////
    // host-visible bytes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i <= 13; i++)
                ext_reg[i] <= (i == 6 || i == 8 || i == 9) ? `RTC_ONE_RST
                                                           : 8'h00;
            ext_reg[11] <= `RTC_CMD_RST;
        end else begin
            if (hund_tick_reg && te) begin
                for (int i = 0; i <= 10; i++)
                    if (is_time(i) && i != 9)
                        ext_reg[i] <= tm_next[i];
                ext_reg[9] <= {ext_reg[9][7:6], 1'b0, tm_next[9][4:0]};
            end
            if (wr_commit && wr_hit)
                ext_reg[wr_off] <= wr_data_reg & wr_mask(wr_off);
        end
    end

    // read data, command flags in the low bits
    always_comb begin
        if (addr > ADDR_W'(`RTC_LAST_OFFSET))
            rd_mux = 8'h00;
        else if (addr[3:0] == `RTC_COMMAND_CONTROL_FLAGS)
            rd_mux = {ext_reg[11][7:2], flag_reg};
        else
            rd_mux = ext_reg[addr[3:0]];
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            data_out_reg <= 8'h00;
        else
            data_out_reg <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog countdown
    assign wd_en = {ext_reg[13], ext_reg[12]} != 16'h0;
    assign wd_load = {(wr_commit && wr_hit
                       && wr_off == `RTC_WATCHDOG_PERIOD_HIGH)
                      ? wr_data_reg : ext_reg[13],
                      (wr_commit && wr_hit
                       && wr_off == `RTC_WATCHDOG_PERIOD_LOW)
                      ? wr_data_reg : ext_reg[12]};
    assign wd_event = hund_tick_reg && wd_en && !wd_access
                      && wd_cnt_reg <= 16'h0001;

    always_ff @(posedge clk) begin
        if (sys_rst)
            wd_cnt_reg <= 16'h0;
        else if (wd_access)
            wd_cnt_reg <= wd_load;
        else if (wd_event)
            wd_cnt_reg <= {ext_reg[13], ext_reg[12]};
        else if (hund_tick_reg && wd_en)
            wd_cnt_reg <= bcd_dec(wd_cnt_reg);
    end

    ////////////////////////////////////////////////////////////////////
    // flags: bit 0 alarm, bit 1 watchdog; set wins over clear
    assign set_ev = {wd_event, tod_event};
    assign clr_ev = {wd_access, alm_access};

    for (genvar g = 0; g < 2; g++) begin : g_flag
        logic [3:0] pulse_cnt_reg;
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                flag_reg[g]   <= 1'b0;
                pulse_cnt_reg <= 4'h0;
            end else if (set_ev[g]) begin
                flag_reg[g]   <= 1'b1;
                pulse_cnt_reg <= PULSE_TKS;
            end else if (clr_ev[g]) begin
                flag_reg[g] <= 1'b0;
            end else if (ext_reg[11][`RTC_CMD_PULSE_BIT] && tick_reg
                         && flag_reg[g]) begin
                if (pulse_cnt_reg <= 4'h1)
                    flag_reg[g] <= 1'b0;
                pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt routing and pin drive
    assign src_act[0] = flag_reg[0]
                        && !ext_reg[11][`RTC_CMD_TOD_MASK_BIT];
    assign src_act[1] = flag_reg[1]
                        && !ext_reg[11][`RTC_CMD_WDOG_MASK_BIT];
    assign a_act = ext_reg[11][`RTC_CMD_ROUTE_BIT] ? src_act[0]
                                                   : src_act[1];
    assign b_act = ext_reg[11][`RTC_CMD_ROUTE_BIT] ? src_act[1]
                                                   : src_act[0];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_a_n_reg  <= 1'b1;
            irq_a_oe_reg <= 1'b0;
            irq_b_reg    <= 1'b0;
            irq_b_oe_reg <= 1'b0;
            sqw_reg      <= 1'b0;
        end else begin
            irq_a_n_reg  <= !a_act;
            irq_a_oe_reg <= a_act && !(SHARED_PIN_A
                            && !ext_reg[9][`RTC_MON_SQW_OFF_BIT]);
            irq_b_reg    <= ext_reg[11][`RTC_CMD_B_DRIVE_BIT];
            irq_b_oe_reg <= b_act;
            sqw_reg      <= sqw_cnt_reg[1];
        end
    end

    assign data_out        = data_out_reg;
    assign data_out_oe     = rd_active;
    assign irq_out_a_n     = irq_a_n_reg;
    assign irq_out_a_oe    = irq_a_oe_reg;
    assign irq_out_b       = irq_b_reg;
    assign irq_out_b_oe    = irq_b_oe_reg;
    assign square_wave_out = sqw_reg;
    assign square_wave_oe  = !ext_reg[9][`RTC_MON_SQW_OFF_BIT];

    ////////////////////////////////////////////////////////////////////
    // checks
    a_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
        rd_active && addr == ADDR_W'(`RTC_DAY_ALARM)
        |=> data_out[6:3] == 4'h0)
        else $error("day alarm unused bits not zero");

    a_osc_stop: assert property (@(posedge clk) disable iff (sys_rst)
        !osc_run [*2] |=> !tick_reg && !hund_tick_reg)
        else $error("tick while oscillator stopped");

    a_frozen_time: assert property (@(posedge clk) disable iff (sys_rst)
        !te && !wr_commit |=> $stable(ext_reg[0]))
        else $error("time register changed while frozen");

    a_internal_run: assert property (@(posedge clk) disable iff (sys_rst)
        hund_tick_reg && !wr_commit |=> tm_reg[0] != $past(tm_reg[0]))
        else $error("internal hundredths did not advance");

    a_wdog_clear: assert property (@(posedge clk) disable iff (sys_rst)
        wd_access && !wd_event
        |=> !flag_reg[1] && wd_cnt_reg == $past(wd_load))
        else $error("watchdog access did not reload or clear");

    a_wdog_fire: assert property (@(posedge clk) disable iff (sys_rst)
        wd_event |=> flag_reg[1] && wd_cnt_reg == {ext_reg[13], ext_reg[12]})
        else $error("watchdog expiry not flagged");

    a_wdog_off: assert property (@(posedge clk) disable iff (sys_rst)
        !wd_en |-> !wd_event)
        else $error("watchdog fired while disabled");

    a_route_a: assert property (@(posedge clk) disable iff (sys_rst)
        ext_reg[11][6] && src_act[0] ##1 1'b1 |-> !irq_out_a_n)
        else $error("alarm not routed to interrupt a");

    a_alarm_every: assert property (@(posedge clk) disable iff (sys_rst)
        hund_tick_reg && c_min && ext_reg[3][7] && ext_reg[5][7]
        && ext_reg[7][7] |=> flag_reg[0])
        else $error("per-minute alarm missed");

endmodule

`default_nettype wire

// *** rtc_consts.svh ***
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// register offsets
`define RTC_HUNDREDTHS_COUNT      4'h0
`define RTC_SECONDS_COUNT         4'h1
`define RTC_MINUTES_COUNT         4'h2
`define RTC_MINUTE_ALARM          4'h3
`define RTC_HOURS_COUNT           4'h4
`define RTC_HOUR_ALARM            4'h5
`define RTC_WEEKDAY_COUNT         4'h6
`define RTC_DAY_ALARM             4'h7
`define RTC_DATE_COUNT            4'h8
`define RTC_MONTH_AND_OSC_CONTROL 4'h9
`define RTC_YEAR_COUNT            4'ha
`define RTC_COMMAND_CONTROL_FLAGS 4'hb
`define RTC_WATCHDOG_PERIOD_LOW   4'hc
`define RTC_WATCHDOG_PERIOD_HIGH  4'hd
`define RTC_LAST_OFFSET           4'hd

// field positions
`define RTC_MON_OSC_STOP_N_BIT    7
`define RTC_MON_SQW_OFF_BIT       6
`define RTC_HR_12H_BIT            6
`define RTC_HR_PM_BIT             5
`define RTC_ALM_MASK_BIT          7
`define RTC_CMD_TRANSFER_BIT      7
`define RTC_CMD_ROUTE_BIT         6
`define RTC_CMD_B_DRIVE_BIT       5
`define RTC_CMD_PULSE_BIT         4
`define RTC_CMD_WDOG_MASK_BIT     3
`define RTC_CMD_TOD_MASK_BIT      2

// reset values
`define RTC_CMD_RST               8'hcc
`define RTC_ONE_RST               8'h01

// timing
`define RTC_CLK_HZ                250000000
`define RTC_TICK_HZ               4096
`define RTC_HUND_HZ               100
`define RTC_PULSE_MS              3
`define RTC_PULSE_TICKS ((`RTC_PULSE_MS * `RTC_TICK_HZ + 999) / 1000)

`endif

// *** rtc_pkg.sv ***
package rtc_pkg;
    typedef logic [7:0]  rtc_byte_t;
    typedef logic [15:0] rtc_bcd16_t;
endpackage

// *** rtc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// host on the strobe bus, changes signals just after a clock edge
module rtc_host_model (
    input  wire logic        clk,
    output logic      [16:0] addr,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic      [7:0]  data_in,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_out_oe
);
    initial begin
        addr = 17'h00000;
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        data_in = 8'h00;
    end

    // write: both strobes low for two edges, data then inverted
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= {13'h0000, a};
        data_in <= d;
        ce_n <= 1'b0;
        we_n <= 1'b0;
        repeat (2) @(posedge clk);
        ce_n <= 1'b1;
        we_n <= 1'b1;
        data_in <= ~d;
        @(posedge clk);
    endtask

    // read: we high, ce and oe low, data taken after it settled
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= {13'h0000, a};
        ce_n <= 1'b0;
        oe_n <= 1'b0;
        repeat (3) @(posedge clk);
        // an undriven bus reads back as the inverse
        d = data_out_oe ? data_out : ~data_out;
        ce_n <= 1'b1;
        oe_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

// *** rtc_alarm_watchdog_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module rtc_alarm_watchdog_tb_top;
    import rtc_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [16:0] addr;
    logic        ce_n, oe_n, we_n, d_oe, a_n, a_oe, b, b_oe, sq, sq_oe;
    rtc_byte_t   data_in, data_out, v, h0;
    logic [1:0]  ev;
    int          num_errors = 0;
    int          n_checks = 0;

    always #2 clk = ~clk;
    assign ev = {b_oe, a_oe};

    rtc_alarm_watchdog #(.CLK_HZ(40960)) i_rtc_alarm_watchdog (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .data_in(data_in),
        .data_out(data_out), .data_out_oe(d_oe), .irq_out_a_n(a_n),
        .irq_out_a_oe(a_oe), .irq_out_b(b), .irq_out_b_oe(b_oe),
        .square_wave_out(sq), .square_wave_oe(sq_oe));

    rtc_host_model i_rtc_host_model (
        .clk(clk), .addr(addr), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .data_in(data_in), .data_out(data_out),
        .data_out_oe(d_oe));

    ////////////////////////////////////////////////////////////////////
    // compare, bounded wait, verdict
    task automatic check(input rtc_byte_t seen, input rtc_byte_t exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_ev(input int i);
        int   n;
        logic p;
        n = 0;
        p = 1'b1;
        // a fresh rising edge, not a level left from before
        while (!(ev[i] === 1'b1 && !p) && n < 5000) begin
            p = ev[i];
            @(posedge clk);
            n++;
        end
        if (!(ev[i] === 1'b1 && !p)) begin
            num_errors++;
            conclude();
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs();
        i_rtc_host_model.rd(4'hb, v);
        check(v, 8'hcc);
        i_rtc_host_model.wr(4'h7, 8'hff);
        i_rtc_host_model.rd(4'h7, v);
        check(v, 8'h87);
        i_rtc_host_model.wr(4'hb, 8'hcf);
        i_rtc_host_model.rd(4'hb, v);
        check(v, 8'hcc);
        i_rtc_host_model.rd(4'he, v);
        check(v, 8'h00);
        check({7'h00, sq_oe}, 8'h01);
        h0 = {7'h00, sq};
        repeat (20) @(posedge clk);
        check({7'h00, sq}, ~h0 & 8'h01);
        $display("test regs done");
    endtask

    task automatic t_wdog();
        i_rtc_host_model.wr(4'hb, 8'hc4);
        i_rtc_host_model.wr(4'hc, 8'h02);
        i_rtc_host_model.wr(4'hd, 8'h00);
        wait_ev(1);
        check({7'h00, b}, 8'h00);
        i_rtc_host_model.rd(4'hb, v);
        check(v & 8'h03, 8'h02);
        i_rtc_host_model.rd(4'hc, v);
        check(v, 8'h02);
        check({7'h00, b_oe}, 8'h00);
        wait_ev(1);
        i_rtc_host_model.wr(4'hb, 8'hd4);
        i_rtc_host_model.wr(4'hc, 8'h01);
        wait_ev(1);
        repeat (100) @(posedge clk);
        check({7'h00, b_oe}, 8'h01);
        repeat (100) @(posedge clk);
        check({7'h00, b_oe}, 8'h00);
        $display("test wdog done");
    endtask

    task automatic t_swap();
        i_rtc_host_model.wr(4'h9, 8'h41);
        @(posedge clk);
        check({7'h00, sq_oe}, 8'h00);
        i_rtc_host_model.wr(4'hb, 8'ha4);
        wait_ev(0);
        check({7'h00, a_n}, 8'h00);
        check({7'h00, b}, 8'h01);
        i_rtc_host_model.wr(4'hb, 8'hac);
        repeat (2) @(posedge clk);
        check({7'h00, a_oe}, 8'h00);
        i_rtc_host_model.rd(4'hb, v);
        check(v & 8'h03, 8'h02);
        i_rtc_host_model.wr(4'hb, 8'ha4);
        i_rtc_host_model.wr(4'hc, 8'h00);
        repeat (2000) @(posedge clk);
        check({7'h00, a_oe}, 8'h00);
        $display("test swap done");
    endtask

    task automatic t_alarm();
        i_rtc_host_model.wr(4'hb, 8'hc8);
        i_rtc_host_model.wr(4'h3, 8'h80);
        i_rtc_host_model.wr(4'h5, 8'h80);
        i_rtc_host_model.wr(4'h7, 8'h80);
        i_rtc_host_model.wr(4'h0, 8'h98);
        i_rtc_host_model.wr(4'h1, 8'h59);
        wait_ev(0);
        i_rtc_host_model.rd(4'hb, v);
        check(v & 8'h03, 8'h01);
        i_rtc_host_model.rd(4'h1, v);
        check(v, 8'h00);
        i_rtc_host_model.rd(4'h3, v);
        check({7'h00, a_oe}, 8'h00);
        i_rtc_host_model.wr(4'h3, 8'h00);
        i_rtc_host_model.wr(4'h5, 8'h72);
        i_rtc_host_model.wr(4'h7, 8'h01);
        i_rtc_host_model.wr(4'h4, 8'h51);
        i_rtc_host_model.wr(4'h2, 8'h59);
        i_rtc_host_model.wr(4'h1, 8'h59);
        i_rtc_host_model.wr(4'h0, 8'h98);
        wait_ev(0);
        i_rtc_host_model.rd(4'h4, v);
        check(v, 8'h72);
        $display("test alarm done");
    endtask

    task automatic t_freeze();
        i_rtc_host_model.wr(4'hb, 8'h4c);
        i_rtc_host_model.rd(4'h0, h0);
        repeat (1000) @(posedge clk);
        i_rtc_host_model.rd(4'h0, v);
        check(v, h0);
        i_rtc_host_model.wr(4'hb, 8'hcc);
        repeat (1000) @(posedge clk);
        i_rtc_host_model.rd(4'h0, v);
        check({7'h00, v !== h0}, 8'h01);
        i_rtc_host_model.wr(4'h9, 8'hc1);
        i_rtc_host_model.rd(4'h0, h0);
        v = {7'h00, sq};
        repeat (1000) @(posedge clk);
        check({7'h00, sq}, v);
        i_rtc_host_model.rd(4'h0, v);
        check(v, h0);
        $display("test freeze done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_wdog();
        t_swap();
        t_alarm();
        t_freeze();
        conclude();
    end
endmodule

`default_nettype wire
